/* File: rtl/slot_bridge_params.svh */
/*
 * Constants for the expansion slot bridge: address windows, slot bus
 * widths and acknowledge timing.
 * Assumes a 20 MHz core clock; included by the bridge sources.
 */
`ifndef SLOT_BRIDGE_PARAMS_SVH
`define SLOT_BRIDGE_PARAMS_SVH

`define CPU_ADDR_W 24
`define SLOT_ADDR_W 20
`define SLOT_ADDR_LSB 1
`define SLOT_ADDR_MSB 20
`define WIN_TAG_MSB 23
`define WIN_TAG_LSB 21
`define MEM_WIN_TAG 3'h6
`define IO_WIN_MSB 23
`define IO_WIN_LSB 17
`define IO_WIN_TAG 7'h7d
`define ACK_STAGES 4
`define IOCLK_DIV_MSB 1
`define ACK_DELAY_NS 500
`define CLK_PERIOD_NS 50

`endif

/* File: rtl/slot_bridge_pkg.sv */
/*
 * Types shared by the expansion slot bridge.
 * Assumes the params header is available on the include path.
 */
package slot_bridge_pkg;
    typedef enum logic [1:0] {
        CYC_IDLE,
        CYC_MEM,
        CYC_IO
    } cycle_kind_t;
endpackage

/* File: rtl/ack_delay_if.sv */
/*
 * Connection between the bridge and its acknowledge delay line.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface ack_delay_if;
    logic active;
    logic strobe;
    logic hold;
    logic ack;
    modport ctrl (output active, output strobe, output hold, input ack);
    modport line (input active, input strobe, input hold, output ack);
endinterface

/* File: rtl/ack_delay_line.sv */
/*
 * Acknowledge delay line: shifts the address strobe level one stage per
 * tick; held cleared outside an access and also cleared while a card waits.
 * Assumes tick pulses arrive once per 8 MHz period equivalent.
 */
`timescale 1ns/1ps
`include "slot_bridge_params.svh"
module ack_delay_line (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    ack_delay_if.line dl
);
    logic [`ACK_STAGES-1:0] stages;
    logic [`ACK_STAGES-1:0] next_stages;
    logic [`ACK_STAGES-1:0] top_bit;

    always_comb begin
        top_bit = {1'b1, {(`ACK_STAGES-1){1'b0}}};
        next_stages = stages;
        if (!dl.active) begin
            next_stages = '0;
        end else if (dl.hold) begin
            next_stages = '0;
        end else if (tick) begin
            next_stages = {stages[`ACK_STAGES-2:0], dl.strobe};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stages <= '0;
        end else begin
            stages <= next_stages;
        end
    end

    assign dl.ack = (stages & top_bit) != '0;
endmodule

/* File: rtl/expansion_slot_bridge.sv */
/*
 * Bridge from a 16-bit processor bus to six 8-bit expansion slots.
 * Assumes processor signals are synchronous to clk; the 14.31818 MHz
 * reference comes from a free-running oscillator input.
 */
// Operation
// - C00000..DFFFFF raises the slot memory window select.
// - FA0000..FBFFFF raises the slot I/O window select.
// - Memory window: write pulls MEMW low, read pulls MEMR low.
// - I/O window: write pulls IOW low, read pulls IOR low.
// - Slot address is processor A20..A1.
// - Slot data uses only the low processor byte lane.
// - 1 MB memory and 64K I/O map onto odd addresses.
// - Either window enables the slot data transceiver, active low.
// - Transceiver direction is inverted read/write.
// - During access, 8 MHz tick divided by 4 drives I/O clock.
// - Outside access the delay line stays cleared, no acknowledge.
// - Delay line shifts strobe each tick; acknowledge after four.
// - WAIT low holds off acknowledge; full delay after release.
// - Continuous colour reference clock goes to the slots.
`timescale 1ns/1ps
`include "slot_bridge_params.svh"
module expansion_slot_bridge
    import slot_bridge_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic system_tick_8mhz,
    input wire logic color_ref_in,
    input wire logic [`CPU_ADDR_W-1:1] cpu_addr,
    input wire logic cpu_as_n,
    input wire logic cpu_lds_n,
    input wire logic cpu_read,
    input wire logic [7:0] cpu_data_out,
    input wire logic slot_wait_n,
    input wire logic [7:0] slot_data_in,
    output logic [`SLOT_ADDR_W-1:0] slot_addr,
    output logic slot_memory_window_select,
    output logic slot_io_window_select,
    output logic memw_n,
    output logic memr_n,
    output logic iow_n,
    output logic ior_n,
    output logic expansion_access_enable_n,
    output logic xcvr_dir,
    output logic [7:0] slot_data_out,
    output logic slot_data_oe_n,
    output logic [7:0] cpu_data_in,
    output logic io_clock,
    output logic color_ref_clock,
    output logic dtack_n
);

    ////////////////////////////////////////////////////////////////////
    // Window decoding

    function automatic cycle_kind_t decode_window(
        input logic [`CPU_ADDR_W-1:1] a,
        input logic strobe_n
    );
        decode_window = CYC_IDLE;
        if (!strobe_n) begin
            if (a[`WIN_TAG_MSB:`WIN_TAG_LSB] == `MEM_WIN_TAG) begin
                decode_window = CYC_MEM;
            end else if (a[`IO_WIN_MSB:`IO_WIN_LSB] == `IO_WIN_TAG) begin
                decode_window = CYC_IO;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Registered slot-side controls

    cycle_kind_t kind;
    logic access;
    logic next_mem_sel, next_io_sel;
    logic next_memw_n, next_memr_n, next_iow_n, next_ior_n;
    logic next_en_n, next_dir, next_oe_n;
    logic [`SLOT_ADDR_W-1:0] next_slot_addr;
    logic [7:0] next_slot_data, next_cpu_data;

    always_comb begin
        kind = decode_window(cpu_addr, cpu_as_n);
        access = kind != CYC_IDLE;
        next_mem_sel = kind == CYC_MEM;
        next_io_sel = kind == CYC_IO;
        next_memw_n = !(next_mem_sel && !cpu_read);
        next_memr_n = !(next_mem_sel && cpu_read);
        next_iow_n = !(next_io_sel && !cpu_read);
        next_ior_n = !(next_io_sel && cpu_read);
        next_en_n = !access;
        next_dir = !cpu_read;
        next_oe_n = !(access && !cpu_read);
        next_slot_addr = cpu_addr[`SLOT_ADDR_MSB:`SLOT_ADDR_LSB];
        next_slot_data = cpu_data_out;
        next_cpu_data = (access && cpu_read && !cpu_lds_n) ?
            slot_data_in : 8'h00;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_memory_window_select <= 1'b0;
            slot_io_window_select <= 1'b0;
            memw_n <= 1'b1;
            memr_n <= 1'b1;
            iow_n <= 1'b1;
            ior_n <= 1'b1;
            expansion_access_enable_n <= 1'b1;
            xcvr_dir <= 1'b0;
            slot_data_oe_n <= 1'b1;
            slot_addr <= '0;
            slot_data_out <= 8'h00;
            cpu_data_in <= 8'h00;
        end else begin
            slot_memory_window_select <= next_mem_sel;
            slot_io_window_select <= next_io_sel;
            memw_n <= next_memw_n;
            memr_n <= next_memr_n;
            iow_n <= next_iow_n;
            ior_n <= next_ior_n;
            expansion_access_enable_n <= next_en_n;
            xcvr_dir <= next_dir;
            slot_data_oe_n <= next_oe_n;
            slot_addr <= next_slot_addr;
            slot_data_out <= next_slot_data;
            cpu_data_in <= next_cpu_data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // 8 MHz tick edge, I/O clock divider and colour reference

    logic tick_q, next_tick_q, tick_rise;
    logic [`IOCLK_DIV_MSB:0] div, next_div;
    logic next_io_clock, next_color;

    always_comb begin
        next_tick_q = system_tick_8mhz;
        tick_rise = system_tick_8mhz && !tick_q;
        next_div = div;
        if (expansion_access_enable_n) begin
            next_div = '0;
        end else if (tick_rise) begin
            next_div = div + 1'b1;
        end
        next_io_clock = !expansion_access_enable_n &&
            next_div[`IOCLK_DIV_MSB];
        next_color = color_ref_in;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_q <= 1'b0;
            div <= '0;
            io_clock <= 1'b0;
            color_ref_clock <= 1'b0;
        end else begin
            tick_q <= next_tick_q;
            div <= next_div;
            io_clock <= next_io_clock;
            color_ref_clock <= next_color;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Acknowledge timing

    ack_delay_if dl_bus ();
    logic next_dtack_n;

    always_comb begin
        dl_bus.active = !expansion_access_enable_n;
        dl_bus.strobe = !cpu_as_n;
        dl_bus.hold = !slot_wait_n;
        next_dtack_n = !(dl_bus.ack && access);
    end

    ack_delay_line delay_line (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick_rise),
        .dl(dl_bus.ctrl)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dtack_n <= 1'b1;
        end else begin
            dtack_n <= next_dtack_n;
        end
    end
endmodule

/* File: verification/slot_bridge_chk.sv */
/* Port checker for the slot bridge, bound to its top module.
   Assumes one clock and an asynchronous active-low reset. */
`timescale 1ns/1ps
module slot_bridge_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [23:1] cpu_addr,
    input wire logic cpu_as_n,
    input wire logic cpu_read,
    input wire logic slot_wait_n,
    input wire logic [19:0] slot_addr,
    input wire logic slot_memory_window_select,
    input wire logic slot_io_window_select,
    input wire logic memw_n,
    input wire logic memr_n,
    input wire logic iow_n,
    input wire logic ior_n,
    input wire logic expansion_access_enable_n,
    input wire logic io_clock,
    input wire logic dtack_n
);
    wire [19:0] addr_bits = cpu_addr[20:1];
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence mem_req; !cpu_as_n && cpu_addr[23:21] == 3'h6; endsequence
    sequence io_req; !cpu_as_n && cpu_addr[23:17] == 7'h7d; endsequence
    sequence card_holds;
        !slot_wait_n ##1 (!slot_wait_n && dtack_n);
    endsequence
    mem_sel_a: assert property (mem_req |=> slot_memory_window_select)
        else $error("no mem select");
    io_sel_a: assert property (io_req |=> slot_io_window_select)
        else $error("no io select");
    mem_cmd_a: assert property (mem_req |=>
        memr_n == !$past(cpu_read) && memw_n == $past(cpu_read))
        else $error("bad mem strobe");
    io_cmd_a: assert property (io_req |=>
        ior_n == !$past(cpu_read) && iow_n == $past(cpu_read))
        else $error("bad io strobe");
    addr_map_a: assert property (!cpu_as_n |=>
        slot_addr == $past(addr_bits)) else $error("bad slot address");
    idle_quiet_a: assert property (expansion_access_enable_n[*3] |->
        dtack_n && !io_clock) else $error("activity while idle");
    ack_min_a: assert property ($fell(expansion_access_enable_n) |->
        dtack_n[*6]) else $error("acknowledge too early");
    wait_hold_a: assert property (card_holds |=> dtack_n)
        else $error("acknowledge during wait");
endmodule
bind expansion_slot_bridge slot_bridge_chk slot_bridge_chk_inst (.*);

/* File: verification/slot_card.sv */
/* Plug-in card model on the slot side.
   Runs on the bridge clock; stall makes it hold WAIT low. */
`timescale 1ns/1ps
module slot_card (
    input wire logic clk,
    input wire logic memr_n,
    input wire logic ior_n,
    input wire logic stall,
    output logic slot_wait_n,
    output logic [7:0] slot_data_in
);
    assign slot_wait_n = !stall;
    initial slot_data_in = 8'h00;
    // Released data lines wander instead of keeping the old byte
    always @(posedge clk) begin
        slot_data_in <= (!memr_n || !ior_n) ? 8'h3c : ~slot_data_in;
    end
endmodule

/* File: verification/expansion_slot_bridge_tb.sv */
/* Bench for the slot bridge: processor cycles in, card model out.
   Assumes the card model and checker are compiled first. */
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    fails++; $display("unexpected %0t bad value", $time); end end
module expansion_slot_bridge_tb;
    logic clk = 1'b0, rst_n = 1'b0, system_tick_8mhz = 1'b0, stall = 1'b0;
    logic color_ref_in = 1'b0, cpu_as_n = 1'b1, cpu_lds_n = 1'b1;
    logic cpu_read = 1'b0;
    logic [23:1] cpu_addr = '0;
    logic [7:0] cpu_data_out = 8'ha5;
    wire slot_wait_n, memw_n, memr_n, iow_n, ior_n, io_clock, dtack_n;
    wire slot_memory_window_select, slot_io_window_select, xcvr_dir;
    wire expansion_access_enable_n, slot_data_oe_n, color_ref_clock;
    wire [7:0] slot_data_in, slot_data_out, cpu_data_in;
    wire [19:0] slot_addr;
    int fails = 0, checks_done = 0, ph = 0;
    expansion_slot_bridge expansion_slot_bridge_inst (.*);
    slot_card slot_card_inst (.*);
    initial begin
        forever #25 clk = ~clk;
    end
    // Two tick rises every five clocks average out to 8 MHz
    always @(posedge clk) begin
        ph <= (ph == 4) ? 0 : ph + 1;
        system_tick_8mhz <= (ph == 0 || ph == 2);
        color_ref_in <= ~color_ref_in;
    end
    task automatic conclude;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic bus(input logic [23:0] a, input logic rd, input int k,
                       input int hold, output int n);
        logic seen;
        logic [4:0] st;
        seen = 1'b0;
        n = 0;
        @(posedge clk);
        cpu_addr <= a[23:1];
        cpu_read <= rd;
        cpu_as_n <= 1'b0;
        cpu_lds_n <= 1'b0;
        stall <= hold > 0;
        @(posedge clk);
        #1;
        `CHK({memw_n, memr_n}, k == 1 ? {rd, !rd} : 2'b11)
        `CHK({iow_n, ior_n}, k == 2 ? {rd, !rd} : 2'b11)
        `CHK(expansion_access_enable_n, k == 0)
        `CHK(xcvr_dir, !rd)
        `CHK(slot_data_oe_n, !(k != 0 && !rd))
        `CHK({slot_memory_window_select, slot_io_window_select}, {k == 1, k == 2})
        `CHK(slot_addr, a[20:1])
        while (dtack_n === 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
            if (n == hold) stall <= 1'b0;
            #1;
            seen |= io_clock;
        end
        if (k == 0) begin
            `CHK(dtack_n, 1'b1)
        end else if (n == 40) begin
            fails++;
            conclude();
        end else begin
            `CHK(seen, 1'b1)
            `CHK(rd ? cpu_data_in : slot_data_out, rd ? 8'h3c : 8'ha5)
        end
        @(posedge clk);
        cpu_as_n <= 1'b1;
        cpu_lds_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        st = {memw_n, memr_n, iow_n, ior_n, expansion_access_enable_n};
        `CHK({st, dtack_n, io_clock}, 7'h7e)
    endtask
    task automatic mem_scenario;
        int n;
        bus(24'hc00001, 1'b1, 1, 0, n);
        `CHK(n >= 7 && n <= 16, 1'b1)
        bus(24'hdfffff, 1'b0, 1, 0, n);
        bus(24'hd60001, 1'b1, 1, 0, n);
        `CHK(slot_addr, 20'hb0000)
    endtask
    task automatic io_scenario;
        int n;
        bus(24'hfa0001, 1'b0, 2, 0, n);
        bus(24'hfbffff, 1'b1, 2, 0, n);
        bus(24'hfa0771, 1'b1, 2, 0, n);
        `CHK(slot_addr[15:0], 16'h03b8)
    endtask
    task automatic outside_scenario;
        int n;
        bus(24'hbfffff, 1'b1, 0, 0, n);
        bus(24'he00001, 1'b0, 0, 0, n);
        bus(24'hf9ffff, 1'b1, 0, 0, n);
        bus(24'hfc0001, 1'b0, 0, 0, n);
    endtask
    task automatic wait_scenario;
        int n;
        bus(24'hfa0003, 1'b1, 2, 20, n);
        `CHK(n >= 27 && n <= 36, 1'b1)
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        mem_scenario();
        io_scenario();
        outside_scenario();
        wait_scenario();
        `CHK(color_ref_clock, !color_ref_in)
        conclude();
    end
endmodule
